/* hdl/spi_clock_stop_port.sv */
// clock-stop serial port, master or slave, single clock domain
//
// What this block does
// [RULE1] bit clock period is divide value plus one, two ticks for divide value zero
// [RULE2] high phase from divide value parity
// [RULE3] low phase from divide value parity
// [RULE4] select bit picks processor or pin clock
// [RULE5] master drives clock and sync, reads rx
// [RULE6] slave takes all clocks and syncs in
// [RULE7] slave forces divider to half processor clock
// [RULE8] both sync polarities set, active low
// [RULE9] master inverts sync for low slave enable
// [RULE10] slave inverts low enable on both syncs
// [RULE11] enable low before rise, transfer at rise
// [RULE12] no-delay mode: launch rise, sample fall
// [RULE13] half-delay mode: launch fall, sample rise
// [RULE14] no-delay master enable low, release timing
// [RULE15] half-delay master enable lead, release timing
// [RULE16] no-delay master data off low phase later
// [RULE17] slave drives after enable, releases after
// [RULE18] software keeps bit rate within limit
// [RULE19] master clock toggles only during words
// [RULE20] slave data floats while enable inactive
`timescale 1ns/1ps
`include "spi_stop_regs.svh"

module spi_clock_stop_port
    import spi_stop_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire spi_cfg_t   cfg,
    input  wire logic       dividerSourceClock,
    input  wire logic       txStart,
    input  wire logic [7:0] txWord,
    input  wire logic       txBitClockIn,
    input  wire logic       txFrameSyncIn,
    input  wire logic       rxFrameSync,
    input  wire logic       rxDataLine,
    output logic            busy,
    output logic [7:0]      rxWord,
    output logic            rxDone,
    output logic            dividerClock,
    output logic            txBitClockOut,
    output logic            txBitClockOe,
    output logic            txFrameSyncOut,
    output logic            txFrameSyncOe,
    output logic            txDataOut,
    output logic            txDataOe,
    output logic            txClockDirection,
    output logic            rxClockDirection,
    output logic            txSyncDirection,
    output logic            rxSyncDirection,
    output logic            txSyncPolarity,
    output logic            rxSyncPolarity
);

    // ----------------------------------------
    // divider setup
    // ----------------------------------------
    logic                     effSel;
    logic [`SPI_DIV_W-1:0]    effDiv;
    logic [`SPI_DIV_W:0]      divPlusOne;
    logic [`SPI_DIV_W-1:0]    hLen;
    logic [`SPI_DIV_W-1:0]    lLen;
    logic                     extPrev;
    logic                     tick;
    logic [`SPI_DIV_W-1:0]    divCnt;
    logic                     divRise;
    logic                     divFall;

    assign effSel     = cfg.master ? cfg.divSel : `SLAVE_DIV_SELECT;   // RULE7
    assign effDiv     = cfg.master ? cfg.divValue : `SLAVE_DIV_VALUE;  // RULE7
    assign divPlusOne = {1'b0, effDiv} + 9'h001;
    always_comb begin
        if (effDiv == 8'h00) begin
            // half a tick is not reachable; zero runs one tick each phase
            hLen = 8'h01;
            lLen = 8'h01;
        end else if (effDiv[0] == 1'b0) begin
            hLen = (effDiv >> 1) + 8'h01;                               // RULE2
            lLen = effDiv >> 1;                                         // RULE3
        end else begin
            hLen = divPlusOne[8:1];                                     // RULE2
            lLen = divPlusOne[8:1];                                     // RULE3
        end
    end

    // pin clock is counted on its rising edges only
    assign tick    = effSel ? 1'b1 : (dividerSourceClock & ~extPrev);  // RULE4
    assign divRise = tick && (divCnt == 8'h00) && !dividerClock;
    assign divFall = tick && (divCnt == 8'h00) && dividerClock;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            extPrev <= 1'b0;
        end else begin
            extPrev <= dividerSourceClock;
        end
    end

    // free-running divider: period is high plus low phase in ticks
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt       <= 8'h00;
            dividerClock <= 1'b0;
        end else if (divRise) begin
            dividerClock <= 1'b1;
            divCnt       <= hLen - 8'h01;                               // RULE1
        end else if (divFall) begin
            dividerClock <= 1'b0;
            divCnt       <= lLen - 8'h01;                               // RULE1
        end else if (tick) begin
            divCnt <= divCnt - 8'h01;
        end
    end

    // ----------------------------------------
    // pin directions and polarities
    // ----------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {txClockDirection, txSyncDirection, rxClockDirection, rxSyncDirection} <= 4'h0;
            {txBitClockOe, txFrameSyncOe, txSyncPolarity, rxSyncPolarity} <= 4'h0;
        end else begin
            {txClockDirection, txSyncDirection} <= {2{cfg.master}};  // RULE5 RULE6
            {txBitClockOe, txFrameSyncOe} <= {2{cfg.master}};  // RULE5
            {rxClockDirection, rxSyncDirection} <= 2'h0;  // RULE5 RULE6
            {txSyncPolarity, rxSyncPolarity} <= {2{`SYNC_POLARITY_LOW}};  // RULE8
        end
    end
    // ----------------------------------------
    // master sequencer
    // ----------------------------------------
    master_state_t             state;
    logic                      modeValid;
    logic                      launchOnRise;
    logic [`SPI_BIT_CNT_W-1:0] fallCount;
    logic                      alignEv;
    logic                      lastFall;

    assign modeValid    = cfg.stopMode[1];
    assign launchOnRise = (cfg.stopMode == `STOP_NO_DELAY);
    // no-delay enables on a fall (low phase lead), half-delay on a rise
    assign alignEv      = launchOnRise ? divFall : divRise;            // RULE14 RULE15
    assign lastFall     = (state == ST_RUN) && divFall
                          && (fallCount == 4'(`SPI_WORD_BITS - 1));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state          <= ST_IDLE;
            txBitClockOut  <= 1'b0;
            txFrameSyncOut <= 1'b1;
            fallCount      <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    txBitClockOut  <= 1'b0;                             // RULE19
                    txFrameSyncOut <= 1'b1;
                    fallCount      <= 4'h0;
                    if (cfg.master && modeValid && txStart) begin
                        state <= ST_PEND;
                    end
                end
                ST_PEND: begin
                    if (alignEv) begin
                        txFrameSyncOut <= 1'b0;                         // RULE9 RULE11
                        state          <= ST_ARM;
                    end
                end
                ST_ARM: begin
                    if (divRise) begin
                        txBitClockOut <= 1'b1;                          // RULE11
                        state         <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (divRise) begin
                        txBitClockOut <= 1'b1;                          // RULE19
                    end else if (divFall) begin
                        txBitClockOut <= 1'b0;
                        fallCount     <= fallCount + 4'h1;
                        if (lastFall) begin
                            state <= ST_TAIL;
                        end
                    end
                end
                ST_TAIL: begin
                    // clock held low; release after period or low phase
                    if (launchOnRise ? divFall : divRise) begin         // RULE14 RULE15
                        txFrameSyncOut <= 1'b1;                         // RULE9
                        state          <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // slave enable and clock edges
    // ----------------------------------------
    logic       seActive;
    logic       sePrev;
    logic       seStart;
    logic       seEnd;
    logic       clkPrev;
    logic [3:0] drvDelay;
    logic       drvPending;

    // both syncs are low-true at the pins
    assign seActive = !cfg.master && !txFrameSyncIn && !rxFrameSync;  // RULE10
    assign seStart  = seActive && !sePrev;
    assign seEnd    = !seActive && sePrev;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sePrev     <= 1'b0;
            clkPrev    <= 1'b0;
            drvDelay   <= 4'h0;
            drvPending <= 1'b0;
        end else begin
            sePrev  <= seActive;
            clkPrev <= txBitClockIn;
            if (seStart) begin
                drvDelay   <= 4'(`SLAVE_DRIVE_CYCLES);                  // RULE17
                drvPending <= 1'b1;
            end else if (!seActive) begin
                drvPending <= 1'b0;
            end else if (drvPending) begin
                drvDelay <= drvDelay - 4'h1;
                if (drvDelay == 4'h1) begin
                    drvPending <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // shared bit engine
    // ----------------------------------------
    logic                      riseEv;
    logic                      fallEv;
    logic                      launchEv;
    logic                      sampleEv;
    logic                      startLaunch;
    logic                      loadWord;
    logic                      dataOff;
    logic                      skipFirst;
    logic [7:0]                txShift;
    logic [7:0]                rxShift;
    logic [`SPI_BIT_CNT_W-1:0] launched;
    logic [`SPI_BIT_CNT_W-1:0] sampled;

    assign riseEv = cfg.master
                    ? (((state == ST_ARM) || (state == ST_RUN)) && divRise)
                    : (seActive && txBitClockIn && !clkPrev);
    assign fallEv = cfg.master
                    ? ((state == ST_RUN) && divFall)
                    : (seActive && !txBitClockIn && clkPrev);
    assign launchEv = launchOnRise ? riseEv : fallEv;                  // RULE12 RULE13
    assign sampleEv = launchOnRise ? fallEv : riseEv;                  // RULE12 RULE13
    assign loadWord = cfg.master ? ((state == ST_IDLE) && txStart && modeValid) : seStart;
    assign startLaunch = cfg.master
                         ? ((state == ST_PEND) && alignEv && !launchOnRise)
                         : (drvPending && seActive && (drvDelay == 4'h1)); // RULE17
    assign dataOff = cfg.master
                     ? (launchOnRise ? ((state == ST_TAIL) && divRise) // RULE16
                                     : lastFall)
                     : seEnd;                                            // RULE17

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            txShift   <= 8'h00;
            launched  <= 4'h0;
            skipFirst <= 1'b0;
            txDataOut <= 1'b0;
            txDataOe  <= 1'b0;
        end else if (loadWord) begin
            txShift   <= txWord;
            launched  <= 4'h0;
            skipFirst <= !cfg.master && launchOnRise;
        end else if (dataOff || (!cfg.master && !seActive)) begin
            txDataOe <= 1'b0;                                           // RULE16 RULE20
        end else if (startLaunch) begin
            txDataOut <= txShift[7];
            txDataOe  <= 1'b1;
            txShift   <= {txShift[6:0], 1'b0};
            launched  <= launched + 4'h1;
        end else if (launchEv && (launched < 4'(`SPI_WORD_BITS))) begin
            if (skipFirst) begin
                // slave already shows the first bit since enable
                skipFirst <= 1'b0;
            end else begin
                txDataOut <= txShift[7];                                // RULE12 RULE13
                txDataOe  <= 1'b1;
                txShift   <= {txShift[6:0], 1'b0};
                launched  <= launched + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rxShift <= 8'h00;
            sampled <= 4'h0;
            rxWord  <= 8'h00;
            rxDone  <= 1'b0;
        end else begin
            rxDone <= 1'b0;
            if (loadWord) begin
                sampled <= 4'h0;
            end else if (sampleEv && (sampled < 4'(`SPI_WORD_BITS))) begin
                rxShift <= {rxShift[6:0], rxDataLine};                  // RULE12 RULE13
                sampled <= sampled + 4'h1;
                if (sampled == 4'(`SPI_WORD_BITS - 1)) begin
                    rxWord <= {rxShift[6:0], rxDataLine};
                    rxDone <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // status
    // ----------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else begin
            busy <= cfg.master ? ((state != ST_IDLE) || loadWord) : seActive;
        end
    end

endmodule // spi_clock_stop_port

/* hdl/spi_stop_pkg.sv */
// types for the clock-stop serial port
package spi_stop_pkg;

    // ----------------------------------------
    // master sequencer states
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_PEND = 5'h02,
        ST_ARM  = 5'h04,
        ST_RUN  = 5'h08,
        ST_TAIL = 5'h10
    } master_state_t;

    // ----------------------------------------
    // configuration carried as one bundle
    // ----------------------------------------
    typedef struct packed {
        logic       master;
        logic [1:0] stopMode;
        logic       divSel;
        logic [7:0] divValue;
    } spi_cfg_t;

endpackage

/* hdl/spi_stop_regs.svh */
// constants for the clock-stop serial port
`ifndef SPI_STOP_REGS_SVH
`define SPI_STOP_REGS_SVH

// ----------------------------------------
// word and divider widths
// ----------------------------------------
`define SPI_WORD_BITS       8
`define SPI_BIT_CNT_W       4
`define SPI_DIV_W           8

// ----------------------------------------
// stop mode encodings
// ----------------------------------------
`define STOP_NO_DELAY       2'h2
`define STOP_HALF_DELAY     2'h3

// ----------------------------------------
// fixed settings
// ----------------------------------------
`define SLAVE_DIV_VALUE     8'h01
`define SLAVE_DIV_SELECT    1'h1
`define SYNC_POLARITY_LOW   1'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define MCLK_PERIOD_NS      10
`define SLAVE_DRIVE_NS      20
`define SLAVE_DRIVE_CYCLES  ((`SLAVE_DRIVE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

/* tb/spi_clock_stop_port_props.sv */
// concurrent checks on the clock-stop serial port pins
`timescale 1ns/1ps
module spi_clock_stop_port_props
    import spi_stop_pkg::*;
(
    input wire logic     mclk,
    input wire logic     reset_n,
    input wire spi_cfg_t cfg,
    input wire logic     txFrameSyncIn,
    input wire logic     rxFrameSync,
    input wire logic     busy,
    input wire logic     rxDone,
    input wire logic     dividerClock,
    input wire logic     txBitClockOut,
    input wire logic     txFrameSyncOut,
    input wire logic     txDataOe,
    input wire logic     txClockDirection,
    input wire logic     rxClockDirection,
    input wire logic     rxSyncDirection,
    input wire logic     txSyncPolarity,
    input wire logic     rxSyncPolarity
);
    // ----------------------------------------
    // phase counters
    // ----------------------------------------
    logic [8:0] sinceRise;
    logic [8:0] sinceFall;
    logic [8:0] sinceSel;
    logic       firstPend;
    logic [8:0] perT;
    logic [8:0] perH;
    logic [8:0] perL;
    logic       timed;
    assign perT  = {1'h0, cfg.divValue} + 9'h001;
    assign perL  = cfg.divValue[0] ? perT >> 1 : {1'h0, cfg.divValue} >> 1;
    assign perH  = cfg.divValue[0] ? perL : perL + 9'h001;
    // zero divide is a designer choice, pin clock has latency: both left out
    assign timed = cfg.master && cfg.divSel && (cfg.divValue != 8'h00);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sinceRise <= 9'h000;
            sinceFall <= 9'h000;
            sinceSel  <= 9'h000;
            firstPend <= 1'h0;
        end else begin
            sinceRise <= $rose(txBitClockOut) ? 9'h001 : sinceRise + 9'h001;
            sinceFall <= $fell(txBitClockOut) ? 9'h001 : sinceFall + 9'h001;
            sinceSel  <= $fell(txFrameSyncOut) ? 9'h001 : sinceSel + 9'h001;
            firstPend <= $fell(txFrameSyncOut) || (firstPend && !$rose(txBitClockOut));
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_period; timed && $rose(txBitClockOut) && !firstPend |-> sinceRise == perT; endproperty
    a_period: assert property (p_period) else $error("bit clock period wrong");
    property p_high; timed && $fell(txBitClockOut) |-> sinceRise == perH; endproperty
    a_high: assert property (p_high) else $error("bit clock high phase wrong");
    property p_low; timed && $rose(txBitClockOut) && !firstPend |-> sinceFall == perL; endproperty
    a_low: assert property (p_low) else $error("bit clock low phase wrong");
    property p_lead;
        timed && $rose(txBitClockOut) && firstPend |-> sinceSel == (cfg.stopMode[0] ? perT : perL);
    endproperty
    a_lead: assert property (p_lead) else $error("enable lead wrong");
    property p_dirs;
        $past(reset_n) |-> txClockDirection == $past(cfg.master) && !rxClockDirection && !rxSyncDirection;
    endproperty
    a_dirs: assert property (p_dirs) else $error("direction bits wrong");
    property p_pol; $past(reset_n) |-> txSyncPolarity && rxSyncPolarity; endproperty
    a_pol: assert property (p_pol) else $error("sync polarity wrong");
    property p_idle; !busy |-> txFrameSyncOut && !txBitClockOut; endproperty
    a_idle: assert property (p_idle) else $error("enable or clock active while idle");
    property p_selclk; txFrameSyncOut |-> !txBitClockOut; endproperty
    a_selclk: assert property (p_selclk) else $error("clock toggles outside frame");
    property p_slave_on;
        !cfg.master && $fell(txFrameSyncIn) && !rxFrameSync |-> ##[1:4] txDataOe;
    endproperty
    a_slave_on: assert property (p_slave_on) else $error("slave data not driven");
    property p_slave_off; !cfg.master && $rose(txFrameSyncIn) |-> ##[1:3] !txDataOe; endproperty
    a_slave_off: assert property (p_slave_off) else $error("slave data not released");
    property p_float; (!cfg.master && rxFrameSync)[*4] |-> !txDataOe; endproperty
    a_float: assert property (p_float) else $error("slave drives while disabled");
    property p_half; (!cfg.master)[*8] |-> dividerClock != $past(dividerClock); endproperty
    a_half: assert property (p_half) else $error("slave divider not half rate");
    c_m2: cover property (cfg.master && !cfg.stopMode[0] && rxDone);
    c_m3: cover property (cfg.master && cfg.stopMode[0] && rxDone);
    c_sl: cover property (!cfg.master && rxDone);
endmodule // spi_clock_stop_port_props

bind spi_clock_stop_port spi_clock_stop_port_props spi_clock_stop_port_props_inst (
    .mclk, .reset_n, .cfg, .txFrameSyncIn, .rxFrameSync, .busy, .rxDone, .dividerClock,
    .txBitClockOut, .txFrameSyncOut, .txDataOe, .txClockDirection, .rxClockDirection,
    .rxSyncDirection, .txSyncPolarity, .rxSyncPolarity
);

/* tb/spi_clock_stop_port_tb.sv */
// self-checking bench for the clock-stop serial port
`timescale 1ns/1ps
`include "spi_stop_regs.svh"
module spi_clock_stop_port_tb
    import spi_stop_pkg::*;
;
    logic mclk, reset_n, srcClk, txStart, pinClk, pinSelN, rxSelN, tbRx, rxLine, miso;
    logic busy, rxDone, dividerClock, txBitClockOut, txBitClockOe, txFrameSyncOut;
    logic txFrameSyncOe, txDataOut, txDataOe, txCd, rxCd, txSd, rxSd, txSp, rxSp;
    logic [7:0] txWord, rxWord, replyWord, gotWord;
    spi_cfg_t   cfg;
    int  mismatches = 0, checked = 0, cycles = 0, rises = 0, dones = 0;
    time tRise, tFall, tSel, tLead, tPer, tHigh, tTail, tOff, tDiv, tDivPer;
    assign rxLine = cfg.master ? miso : tbRx;
    spi_clock_stop_port spi_clock_stop_port_inst (.mclk(mclk), .reset_n(reset_n), .cfg(cfg),
        .dividerSourceClock(srcClk), .txStart(txStart), .txWord(txWord),
        .txBitClockIn(pinClk), .txFrameSyncIn(pinSelN), .rxFrameSync(rxSelN),
        .rxDataLine(rxLine), .busy(busy), .rxWord(rxWord), .rxDone(rxDone),
        .dividerClock(dividerClock), .txBitClockOut(txBitClockOut),
        .txBitClockOe(txBitClockOe), .txFrameSyncOut(txFrameSyncOut),
        .txFrameSyncOe(txFrameSyncOe), .txDataOut(txDataOut), .txDataOe(txDataOe),
        .txClockDirection(txCd), .rxClockDirection(rxCd), .txSyncDirection(txSd),
        .rxSyncDirection(rxSd), .txSyncPolarity(txSp), .rxSyncPolarity(rxSp));
    spi_peripheral_model spi_peripheral_model_inst (.sclk(txBitClockOut),
        .selN(txFrameSyncOut), .mosi(txDataOut), .lateMode(cfg.stopMode[0]),
        .replyWord(replyWord), .miso(miso), .gotWord(gotWord));
    // ----------------------------------------
    // clocks, edge timing monitors, limit
    // ----------------------------------------
    always #5 mclk = ~mclk;
    always #20 srcClk = ~srcClk;
    always @(negedge txFrameSyncOut) begin tSel = $time; rises = 0; end
    always @(posedge txBitClockOut) begin
        if (rises == 0) tLead = $time - tSel;
        else tPer = $time - tRise;
        tRise = $time;
        rises++;
    end
    always @(negedge txBitClockOut) begin tHigh = $time - tRise; tFall = $time; end
    always @(posedge txFrameSyncOut) tTail = $time - tFall;
    always @(negedge txDataOe) tOff = $time - tFall;
    always @(posedge dividerClock) begin tDivPer = $time - tDiv; tDiv = $time; end
    always @(posedge mclk) begin
        if (rxDone === 1'h1) dones++;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("unexpected cycle limit: expected below 20000, seen 20000");
            give_verdict();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic master_word(input logic [1:0] md, input logic sel, input int d,
                               input logic [7:0] mw, input logic [7:0] sw);
        int s, l;
        s = sel ? 10 : 40;
        l = (d % 2) ? (d + 1) / 2 : d / 2;
        cfg = '{master: 1'h1, stopMode: md, divSel: sel, divValue: 8'(d)};
        replyWord = sw;
        txWord = mw;
        tick(3);
        dones = 0;
        txStart = 1'h1;
        tick(1);
        txStart = 1'h0;
        while (busy !== 1'h0) tick(1);
        check("word at peripheral", mw, gotWord);
        check("word received", sw, rxWord);
        check("clock pulses", 8, rises);
        check("done pulses", 1, dones);
        check("period", (d + 1) * s, 32'(tPer));
        check("high phase", ((d % 2) ? l : l + 1) * s, 32'(tHigh));
        check("enable lead", (md[0] ? d + 1 : l) * s, 32'(tLead));
        check("enable tail", (md[0] ? l : d + 1) * s, 32'(tTail));
        if (!md[0]) check("data release", l * s, 32'(tOff));
        check("master pins", 8'hAF, {txCd, rxCd, txSd, rxSd, txSp, rxSp, txBitClockOe, txFrameSyncOe});
        $display("master word mode %0d div %0d source %0d done", md, d, sel);
    endtask
    task automatic slave_word(input logic [1:0] md, input logic [7:0] mw, input logic [7:0] sw);
        int i;
        logic [7:0] cap;
        cfg = '{master: 1'h0, stopMode: md, divSel: 1'h0, divValue: 8'h05};
        txWord = mw;
        tbRx = sw[7];
        tick(12);
        dones = 0;
        check("slave half rate", 20, 32'(tDivPer));
        check("slave pins", 8'h0C, {txCd, rxCd, txSd, rxSd, txSp, rxSp, txBitClockOe, txFrameSyncOe});
        rxSelN = 1'h0;
        tick(6);
        check("one sync only", 0, txDataOe);
        pinSelN = 1'h0;
        tick(`SLAVE_DRIVE_CYCLES + 2);
        check("first bit", {1'h1, mw[7]}, {txDataOe, txDataOut});
        for (i = 7; i >= 0; i--) begin
            if (!md[0] && i < 7) tbRx = sw[i];
            if (md[0]) cap[i] = txDataOut;
            pinClk = 1'h1;
            tick(4);
            if (!md[0]) cap[i] = txDataOut;
            pinClk = 1'h0;
            if (md[0] && i > 0) tbRx = sw[i - 1];
            tick(4);
        end
        pinSelN = 1'h1;
        rxSelN = 1'h1;
        tbRx = ~tbRx;
        tick(4);
        check("slave sent", mw, cap);
        check("slave received", sw, rxWord);
        check("slave done", 1, dones);
        check("slave released", 0, txDataOe);
        $display("slave word mode %0d done", md);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        mclk = 1'h0;
        srcClk = 1'h0;
        reset_n = 1'h0;
        cfg = '{master: 1'h1, stopMode: `STOP_NO_DELAY, divSel: 1'h1, divValue: 8'h01};
        {txStart, pinClk, tbRx, txWord, replyWord} = 19'h0;
        {pinSelN, rxSelN} = 2'h3;
        repeat (10) @(posedge mclk);
        check("reset outputs", 3'h4, {txFrameSyncOut, txDataOe, busy});
        #1 reset_n = 1'h1;
        tick(2);
        for (int m = 0; m < 2; m++) begin
            for (int d = 1; d < 5; d++) begin
                master_word(m ? `STOP_HALF_DELAY : `STOP_NO_DELAY, 1'h1, d,
                            8'hA5 ^ 8'(d), 8'h3C + 8'(m));
            end
        end
        master_word(`STOP_NO_DELAY, 1'h0, 1, 8'hC3, 8'h5A);
        cfg.stopMode = 2'h0;
        txStart = 1'h1;
        tick(1);
        txStart = 1'h0;
        tick(20);
        check("refused start", 2'h1, {busy, txFrameSyncOut});
        $display("refused start done");
        slave_word(`STOP_NO_DELAY, 8'h96, 8'h4B);
        slave_word(`STOP_HALF_DELAY, 8'h69, 8'hD2);
        give_verdict();
    end
endmodule // spi_clock_stop_port_tb

/* tb/spi_peripheral_model.sv */
// external slave peripheral facing the port in master mode
`timescale 1ns/1ps
module spi_peripheral_model (
    input  wire logic       sclk,
    input  wire logic       selN,
    input  wire logic       mosi,
    input  wire logic       lateMode,
    input  wire logic [7:0] replyWord,
    output logic            miso,
    output logic [7:0]      gotWord
);
    logic [7:0] shiftOut;
    initial begin
        miso     = 1'h0;
        gotWord  = 8'h00;
        shiftOut = 8'h00;
    end
    // ----------------------------------------
    // select, launch and capture
    // ----------------------------------------
    always @(negedge selN) begin
        shiftOut = replyWord;
        if (lateMode) begin
            #1 miso = shiftOut[7];
            shiftOut = shiftOut << 1;
        end
    end
    always @(posedge sclk) begin
        if (lateMode) gotWord = {gotWord[6:0], mosi};
        else begin
            #1 miso = shiftOut[7];
            shiftOut = shiftOut << 1;
        end
    end
    always @(negedge sclk) begin
        if (!lateMode) gotWord = {gotWord[6:0], mosi};
        else begin
            #1 miso = shiftOut[7];
            shiftOut = shiftOut << 1;
        end
    end
    // released line must not keep its last bit
    always @(posedge selN) #1 miso = ~miso;
endmodule // spi_peripheral_model
